// >>> src/rx_gain_pkg.sv
// constants and types shared by the receiver gain decision logic
package rx_gain_pkg;

  // ---------------------------------------------------------------
  // gain table index
  // ---------------------------------------------------------------
  localparam int         IDX_W      = 8;
  localparam logic [7:0] IDX_FLOOR  = 8'hBB;   // lowest usable table row
  localparam logic [7:0] IDX_CEIL   = 8'hFF;   // highest row, no attenuation
  localparam logic [7:0] IDX_RESET  = 8'hFF;   // start at full gain
  localparam logic [3:0] MAN_STEP   = 4'h1;    // one row per manual request

  // ---------------------------------------------------------------
  // digital gain word
  // ---------------------------------------------------------------
  localparam int          DGAIN_W        = 11;      // unsigned, lsb is 0.05 dB
  localparam logic [3:0]  DGAIN_PER_ROW  = 4'hA;    // 0.5 dB per row over 0.05 dB
  localparam logic [10:0] DGAIN_ZERO     = 11'h000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS     = 1000;   // quiet time after an autonomous step
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // detector and counter widths
  // ---------------------------------------------------------------
  localparam int PWR_W = 16;
  localparam int WIN_W = 16;
  localparam int CNT_W = 8;

  // ---------------------------------------------------------------
  // decision state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_TRACK  = 1'b0,
    ST_SETTLE = 1'b1
  } gain_state_type;

endpackage

// >>> src/rx_gain_control_logic.sv
// receiver gain decision logic: autonomous and manual gain modes
`timescale 1ns/1ps
module rx_gain_control_logic #(
  parameter int SETTLE_CYC = rx_gain_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_n_in,
  // mode and options
  input  wire logic                          mode_manual_in,
  input  wire logic                          detect_enable_in,
  input  wire logic                          fast_attack_in,
  input  wire logic                          fast_recovery_in,
  input  wire logic                          compensate_in,
  // peak detector results
  input  wire logic                          peak_strobe_in,
  input  wire logic [1:0]                    peak_high_in,
  input  wire logic                          peak_low_in,
  // power detector results
  input  wire logic                          power_strobe_in,
  input  wire logic [rx_gain_pkg::PWR_W-1:0] power_level_in,
  input  wire logic [rx_gain_pkg::PWR_W-1:0] power_high_thr_in,
  input  wire logic [rx_gain_pkg::PWR_W-1:0] power_low_thr_in,
  // configuration
  input  wire logic [rx_gain_pkg::WIN_W-1:0] window_len_in,
  input  wire logic [rx_gain_pkg::CNT_W-1:0] over_count_in,
  input  wire logic [rx_gain_pkg::CNT_W-1:0] under_count_in,
  input  wire logic [rx_gain_pkg::IDX_W-1:0] min_index_in,
  input  wire logic [rx_gain_pkg::IDX_W-1:0] max_index_in,
  input  wire logic [3:0]                    step_attack_in,
  input  wire logic [3:0]                    step_recover_in,
  input  wire logic [3:0]                    step_fast_in,
  // manual commands
  input  wire logic                          cmd_inc_in,
  input  wire logic                          cmd_dec_in,
  input  wire logic                          cmd_load_in,
  input  wire logic [rx_gain_pkg::IDX_W-1:0] cmd_index_in,
  // digital_io_pins requests
  input  wire logic                          io_inc_pin_in,
  input  wire logic                          io_dec_pin_in,
  // gain outputs
  output logic [rx_gain_pkg::IDX_W-1:0]      gain_index_out,
  output logic [rx_gain_pkg::DGAIN_W-1:0]    digital_gain_out,
  // status
  output logic                               overrange_out,
  output logic                               underrange_out,
  output logic                               settling_out,
  // digital_io_pins indications
  output logic                               io_over_pin_out,
  output logic                               io_under_pin_out
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  localparam int SET_W = $clog2(SETTLE_CYC + 1);
  // refuse settle lengths the counter cannot serve
  if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_settle_check
    $error("SETTLE_CYC out of range");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rx_gain_pkg::gain_state_type        state_r,    state_nxt;
  logic [SET_W-1:0]                   settle_r,   settle_nxt;
  logic [rx_gain_pkg::WIN_W-1:0]      win_r,      win_nxt;
  logic [rx_gain_pkg::CNT_W-1:0]      ov_cnt_r,   ov_cnt_nxt;
  logic [rx_gain_pkg::CNT_W-1:0]      un_cnt_r,   un_cnt_nxt;
  logic [rx_gain_pkg::IDX_W-1:0]      idx_r,      idx_nxt;
  logic [rx_gain_pkg::DGAIN_W-1:0]    dgain_r,    dgain_nxt;
  logic                               over_r,     over_nxt;
  logic                               under_r,    under_nxt;
  logic                               pin_ov_r,   pin_ov_nxt;
  logic                               pin_un_r,   pin_un_nxt;
  logic [2:0]                         inc_sync_r;
  logic [2:0]                         dec_sync_r;
  logic                               inc_req;
  logic                               dec_req;
  logic                               track;
  logic                               win_end;
  logic                               overload;
  logic                               underload;
  logic                               peak_over;
  logic                               peak_under;
  logic                               pwr_over;
  logic                               pwr_under;
  logic                               fast_hit;
  logic                               over_evt;
  logic                               under_evt;
  logic [rx_gain_pkg::IDX_W-1:0]      lo;
  logic [rx_gain_pkg::IDX_W-1:0]      hi;
  logic [rx_gain_pkg::CNT_W:0]        ov_acc;
  logic [rx_gain_pkg::CNT_W:0]        un_acc;
  logic [rx_gain_pkg::IDX_W-1:0]      diff;
  logic [11:0]                        prod;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // step down with floor clamp
  function automatic logic [7:0] step_dn(input logic [7:0] idx, input logic [3:0] st,
                                         input logic [7:0] fl);
    logic [8:0] lim;
    lim = {1'b0, fl} + {5'h00, st};
    if ({1'b0, idx} < lim) begin
      return fl;
    end
    return idx - {4'h0, st};
  endfunction

  // step up with ceiling clamp
  function automatic logic [7:0] step_up(input logic [7:0] idx, input logic [3:0] st,
                                         input logic [7:0] cl);
    logic [8:0] sum;
    sum = {1'b0, idx} + {5'h00, st};
    if (sum > {1'b0, cl}) begin
      return cl;
    end
    return sum[7:0];
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // stage 0 feeds stage 1 only; edges taken from stages 1 and 2
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inc_sync_r <= 3'h0;
      dec_sync_r <= 3'h0;
    end else begin
      inc_sync_r <= {inc_sync_r[1:0], io_inc_pin_in};
      dec_sync_r <= {dec_sync_r[1:0], io_dec_pin_in};
    end
  end

  // ---------------------------------------------------------------
  // decision logic
  // ---------------------------------------------------------------
  // next values of gain, window counters and indications
  always_comb begin
    inc_req    = cmd_inc_in | (inc_sync_r[1] & ~inc_sync_r[2]);
    dec_req    = cmd_dec_in | (dec_sync_r[1] & ~dec_sync_r[2]);
    lo         = (min_index_in < rx_gain_pkg::IDX_FLOOR) ? rx_gain_pkg::IDX_FLOOR : min_index_in;
    hi         = (max_index_in < lo) ? lo : max_index_in;
    track      = (state_r == rx_gain_pkg::ST_TRACK);
    win_end    = ({1'b0, win_r} + 17'h0_0001) >= {1'b0, window_len_in};
    overload   = peak_strobe_in & (|peak_high_in);
    underload  = peak_strobe_in & ~peak_low_in;
    ov_acc     = {1'b0, ov_cnt_r} + {{rx_gain_pkg::CNT_W{1'b0}}, overload};
    un_acc     = {1'b0, un_cnt_r} + {{rx_gain_pkg::CNT_W{1'b0}}, underload};
    peak_over  = detect_enable_in & track & overload
               & (ov_acc >= {1'b0, over_count_in});
    peak_under = detect_enable_in & track & win_end
               & (un_acc >= {1'b0, under_count_in});
    pwr_over   = detect_enable_in & track & power_strobe_in
               & (power_level_in > power_high_thr_in);
    pwr_under  = detect_enable_in & track & power_strobe_in
               & ~(power_level_in > power_low_thr_in);
    fast_hit   = detect_enable_in & peak_strobe_in & peak_high_in[1]
               & (fast_attack_in | fast_recovery_in);
    over_evt   = peak_over | pwr_over | fast_hit;
    under_evt  = peak_under | pwr_under;
    state_nxt  = state_r;
    settle_nxt = settle_r;
    idx_nxt    = idx_r;
    win_nxt    = win_r;
    ov_cnt_nxt = ov_cnt_r;
    un_cnt_nxt = un_cnt_r;
    // window accumulation, saturating counts
    if (track) begin
      if (win_end || peak_over) begin
        win_nxt    = '0;
        ov_cnt_nxt = '0;
        un_cnt_nxt = '0;
      end else begin
        win_nxt    = win_r + 16'h0001;
        ov_cnt_nxt = ov_acc[rx_gain_pkg::CNT_W] ? ov_cnt_r : ov_acc[rx_gain_pkg::CNT_W-1:0];
        un_cnt_nxt = un_acc[rx_gain_pkg::CNT_W] ? un_cnt_r : un_acc[rx_gain_pkg::CNT_W-1:0];
      end
    end else if (settle_r == '0) begin
      state_nxt = rx_gain_pkg::ST_TRACK;
    end else begin
      settle_nxt = settle_r - 1'b1;
    end
    if (!mode_manual_in) begin
      // autonomous steps, attack has priority
      if (over_evt) begin
        idx_nxt = step_dn(idx_r, fast_hit ? step_fast_in : step_attack_in, lo);
      end else if (under_evt) begin
        idx_nxt = step_up(idx_r, (fast_recovery_in & pwr_under) ? step_fast_in
                                                                : step_recover_in, hi);
      end
      if (over_evt || under_evt) begin
        state_nxt  = rx_gain_pkg::ST_SETTLE;
        settle_nxt = SET_W'(SETTLE_CYC - 1);
        win_nxt    = '0;
        ov_cnt_nxt = '0;
        un_cnt_nxt = '0;
      end
    end else begin
      // manual steps only on request
      if (cmd_load_in) begin
        idx_nxt = (cmd_index_in < lo) ? lo : ((cmd_index_in > hi) ? hi : cmd_index_in);
      end else if (inc_req && !dec_req) begin
        idx_nxt = step_up(idx_r, rx_gain_pkg::MAN_STEP, hi);
      end else if (dec_req && !inc_req) begin
        idx_nxt = step_dn(idx_r, rx_gain_pkg::MAN_STEP, lo);
      end
    end
    // compensation: attenuation in rows times ten lsb
    diff      = rx_gain_pkg::IDX_CEIL - idx_nxt;
    prod      = {4'h0, diff} * {8'h00, rx_gain_pkg::DGAIN_PER_ROW};
    dgain_nxt = compensate_in ? prod[10:0] : rx_gain_pkg::DGAIN_ZERO;
    over_nxt   = over_evt;
    under_nxt  = under_evt & ~over_evt;
    pin_ov_nxt = mode_manual_in & detect_enable_in & over_evt;
    pin_un_nxt = mode_manual_in & detect_enable_in & under_evt & ~over_evt;
  end

  // registers of the decision logic
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r  <= rx_gain_pkg::ST_TRACK;
      settle_r <= '0;
      win_r    <= '0;
      ov_cnt_r <= '0;
      un_cnt_r <= '0;
      idx_r    <= rx_gain_pkg::IDX_RESET;
      dgain_r  <= rx_gain_pkg::DGAIN_ZERO;
      over_r   <= 1'b0;
      under_r  <= 1'b0;
      pin_ov_r <= 1'b0;
      pin_un_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      win_r    <= win_nxt;
      ov_cnt_r <= ov_cnt_nxt;
      un_cnt_r <= un_cnt_nxt;
      idx_r    <= idx_nxt;
      dgain_r  <= dgain_nxt;
      over_r   <= over_nxt;
      under_r  <= under_nxt;
      pin_ov_r <= pin_ov_nxt;
      pin_un_r <= pin_un_nxt;
    end
  end

  // outputs straight from flops
  assign gain_index_out   = idx_r;
  assign digital_gain_out = dgain_r;
  assign overrange_out    = over_r;
  assign underrange_out   = under_r;
  assign settling_out     = (state_r == rx_gain_pkg::ST_SETTLE);
  assign io_over_pin_out  = pin_ov_r;
  assign io_under_pin_out = pin_un_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_manual_hold: assert property (mode_manual_in && !cmd_load_in && !inc_req && !dec_req
                                    |=> $stable(gain_index_out))
    else $error("gain moved in manual mode without request");
  chk_attack_down: assert property (!mode_manual_in && over_evt
                                    |=> gain_index_out <= $past(gain_index_out))
    else $error("attack raised gain");
  chk_recover_up: assert property (!mode_manual_in && under_evt && !over_evt
                                   |=> gain_index_out >= $past(gain_index_out))
    else $error("recovery lowered gain");
  chk_index_range: assert property (gain_index_out >= 8'hBB)
    else $error("gain index below table floor");
  chk_comp_word: assert property (compensate_in |=> digital_gain_out ==
                                  11'((8'hFF - gain_index_out) * 10))
    else $error("compensation word mismatch");
  chk_both_prio: assert property (over_evt && under_evt |=> overrange_out && !underrange_out)
    else $error("recovery not suppressed");
  chk_pins_gate: assert property (!mode_manual_in |=> !io_over_pin_out && !io_under_pin_out)
    else $error("indication pins driven outside manual mode");
  chk_power_over: assert property (detect_enable_in && !settling_out && power_strobe_in
                                   && power_level_in > power_high_thr_in |=> overrange_out)
    else $error("power overrange missed");
  chk_settle_len: assert property ($rose(settling_out) && !mode_manual_in && !fast_hit
                                   |-> settling_out [*2])
    else $error("settle period too short");

endmodule

// >>> dv/bb_gain_partner.sv
// baseband-side model that issues manual gain commands and pin requests
`timescale 1ns/1ps
module bb_gain_partner (
  // clock
  input  wire logic       ref_clk_in,
  // manual commands
  output logic            cmd_inc_out,
  output logic            cmd_dec_out,
  output logic            cmd_load_out,
  output logic [7:0]      cmd_index_out,
  // digital_io_pins requests
  output logic            io_inc_pin_out,
  output logic            io_dec_pin_out
);
  // idle levels at time zero
  initial begin
    {cmd_inc_out, cmd_dec_out, cmd_load_out, io_inc_pin_out, io_dec_pin_out} = 5'h00;
    cmd_index_out = 8'h00;
  end

  // one-cycle command pulse: 0 inc, 1 dec, 2 load
  task automatic send_cmd(input logic [1:0] kind, input logic [7:0] val);
    @(negedge ref_clk_in);
    cmd_index_out = val;
    cmd_inc_out = (kind == 2'h0);
    cmd_dec_out = (kind == 2'h1);
    cmd_load_out = (kind == 2'h2);
    @(negedge ref_clk_in);
    {cmd_inc_out, cmd_dec_out, cmd_load_out} = 3'h0;
    cmd_index_out = ~val; // released value is not held
  endtask

  // pin request held long enough to pass the synchroniser
  task automatic pin_req(input logic up);
    @(negedge ref_clk_in);
    io_inc_pin_out = up;
    io_dec_pin_out = ~up;
    repeat (5) @(negedge ref_clk_in);
    {io_inc_pin_out, io_dec_pin_out} = 2'h0;
  endtask
endmodule

// >>> dv/rx_gain_control_logic_tb_top.sv
// self-checking bench for the receiver gain decision logic
`timescale 1ns/1ps
module rx_gain_control_logic_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, rst_n, man, det, fa, fr, comp, pk_stb, pk_low, pw_stb;
  logic [1:0]  pk_high;
  logic [15:0] pw_lvl, win;
  logic [7:0]  over_cnt, under_cnt, idx, exp_idx, c_idx, mx;
  logic [3:0]  st_att, st_rec, st_fast;
  logic        c_inc, c_dec, c_load, p_inc, p_dec, ovr, unr, stl, io_ovr, io_unr;
  logic [10:0] dg;
  int          mismatches, cmp_count;

  // clock and time-zero inputs
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, man, fa, fr, comp, pk_stb, pk_low, pw_stb, pk_high} = 10'h000;
    det = 1'b1;
    {pw_lvl, win} = {16'h4000, 16'h0010};
    {over_cnt, under_cnt} = {8'hFF, 8'hFF};
    mx = 8'hFF;
    {st_att, st_rec, st_fast} = {4'h3, 4'h5, 4'h8};
    {mismatches, cmp_count} = '0;
  end

  bb_gain_partner u_bb (.ref_clk_in(clk), .cmd_inc_out(c_inc), .cmd_dec_out(c_dec), .cmd_load_out(c_load),
    .cmd_index_out(c_idx), .io_inc_pin_out(p_inc), .io_dec_pin_out(p_dec));

  rx_gain_control_logic #(.SETTLE_CYC(2)) DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .mode_manual_in(man),
    .detect_enable_in(det), .fast_attack_in(fa), .fast_recovery_in(fr), .compensate_in(comp),
    .peak_strobe_in(pk_stb), .peak_high_in(pk_high), .peak_low_in(pk_low), .power_strobe_in(pw_stb),
    .power_level_in(pw_lvl), .power_high_thr_in(16'h8000), .power_low_thr_in(16'h1000),
    .window_len_in(win), .over_count_in(over_cnt), .under_count_in(under_cnt),
    .min_index_in(rx_gain_pkg::IDX_FLOOR), .max_index_in(mx), .step_attack_in(st_att),
    .step_recover_in(st_rec), .step_fast_in(st_fast), .cmd_inc_in(c_inc), .cmd_dec_in(c_dec),
    .cmd_load_in(c_load), .cmd_index_in(c_idx), .io_inc_pin_in(p_inc), .io_dec_pin_in(p_dec),
    .gain_index_out(idx), .digital_gain_out(dg), .overrange_out(ovr), .underrange_out(unr),
    .settling_out(stl), .io_over_pin_out(io_ovr), .io_under_pin_out(io_unr));

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic note(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_idx(input logic [7:0] exp);
    note(idx === exp, {8'h00, idx}, {8'h00, exp});
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    note(got === exp, {15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_dg(input logic [10:0] exp);
    note(dg === exp, {5'h00, dg}, {5'h00, exp});
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // expected index after a clamped step, and its compensation word
  function automatic logic [7:0] nxt(input logic [7:0] i, input int d);
    int v;
    v = int'(i) + d;
    v = (v > 255) ? 255 : ((v < 187) ? 187 : v);
    return v[7:0];
  endfunction
  function automatic logic [10:0] dg_of(input logic [7:0] i);
    return comp ? 11'((9'h0FF - i) * 11'h00A) : 11'h000;
  endfunction

  // ---------------------------------------------------------------
  // detector strobes and reset
  // ---------------------------------------------------------------
  task automatic strobe(input logic pw, input logic [15:0] lvl, input logic pk, input logic [1:0] hi,
                        input logic lo);
    @(negedge clk);
    {pw_stb, pw_lvl, pk_stb, pk_high, pk_low} = {pw, lvl, pk, hi, lo};
    @(negedge clk);
    {pw_stb, pk_stb} = 2'h0;
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    exp_idx = 8'hFF;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    do_reset();
    chk_idx(8'hFF);
    chk_dg(11'h000);
    chk_flag(ovr, 1'b0);
    chk_flag(stl, 1'b0);
    done("reset");
  endtask
  task automatic t_power();
    comp = 1'b1;
    for (int i = 0; i < 4; i++) begin
      repeat (6) @(negedge clk);
      strobe(1'b1, (i < 2) ? 16'h9000 : 16'h0800, 1'b0, 2'h0, 1'b1);
      exp_idx = nxt(exp_idx, (i < 2) ? -3 : 5);
      chk_idx(exp_idx);
      chk_flag(ovr, i < 2);
      chk_flag(stl, 1'b1);
      chk_flag(unr, i >= 2);
      chk_flag(io_ovr | io_unr, 1'b0);
      chk_dg(dg_of(exp_idx));
    end
    done("power");
  endtask
  task automatic t_fast();
    fa = 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        fr = 1'b1;
        repeat (6) @(negedge clk);
      end
      strobe(i == 2, 16'h0800, i < 2, 2'h2, 1'b1);
      exp_idx = nxt(exp_idx, (i < 2) ? -8 : 8);
      chk_idx(exp_idx);
    end
    {fa, fr} = 2'h0;
    done("fast");
  endtask
  task automatic t_peak();
    {over_cnt, under_cnt, st_rec} = {8'h03, 8'h02, 4'h2};
    do_reset();
    for (int i = 0; i < 3; i++) begin
      strobe(1'b0, 16'h4000, 1'b1, 2'h1, 1'b1);
      exp_idx = nxt(exp_idx, (i == 2) ? -3 : 0);
      chk_idx(exp_idx);
      chk_flag(ovr, i == 2);
    end
    repeat (6) @(negedge clk);
    repeat (2) strobe(1'b0, 16'h4000, 1'b1, 2'h0, 1'b0);
    for (int n = 0; n < 40 && unr !== 1'b1; n++) @(negedge clk);
    chk_flag(unr, 1'b1);
    exp_idx = nxt(exp_idx, 2);
    chk_idx(exp_idx);
    {over_cnt, under_cnt} = {8'h01, 8'hFF};
    repeat (6) @(negedge clk);
    strobe(1'b1, 16'h0800, 1'b1, 2'h1, 1'b1);
    exp_idx = nxt(exp_idx, -3);
    chk_idx(exp_idx);
    chk_flag(ovr, 1'b1);
    chk_flag(unr, 1'b0);
    done("peak");
  endtask
  task automatic t_manual();
    u_bb.send_cmd(2'h0, 8'h00);
    chk_idx(exp_idx);
    man = 1'b1;
    u_bb.send_cmd(2'h0, 8'h00);
    chk_idx(nxt(exp_idx, 1));
    u_bb.send_cmd(2'h1, 8'h00);
    chk_idx(exp_idx);
    u_bb.send_cmd(2'h2, 8'h64);
    chk_idx(8'hBB);
    u_bb.send_cmd(2'h1, 8'h00);
    chk_idx(8'hBB);
    u_bb.pin_req(1'b1);
    chk_idx(8'hBC);
    strobe(1'b1, 16'h9000, 1'b0, 2'h0, 1'b1);
    chk_idx(8'hBC);
    chk_flag(io_ovr, 1'b1);
    strobe(1'b1, 16'h0800, 1'b0, 2'h0, 1'b1);
    chk_flag(io_unr, 1'b1);
    det = 1'b0;
    strobe(1'b1, 16'h9000, 1'b0, 2'h0, 1'b1);
    chk_flag(io_ovr, 1'b0);
    chk_flag(ovr, 1'b0);
    u_bb.pin_req(1'b0);
    chk_idx(8'hBB);
    mx = 8'hC0;
    u_bb.send_cmd(2'h2, 8'hF0);
    chk_idx(8'hC0);
    done("manual");
  endtask

  // main sequence and watchdog
  initial begin
    t_reset();
    t_power();
    t_fast();
    t_peak();
    t_manual();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
